//--- rtl/mcg_params.svh
// Register offsets, field positions, reset values and timing counts of the clock generator
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH
`define MCG_OFF_CTRL1 12'h000
`define MCG_OFF_CTRL2 12'h004
`define MCG_OFF_TRIM 12'h008
`define MCG_OFF_STAT 12'h00C
`define MCG_OFF_RSTAT 12'h010
// Control one fields
`define MCG_C1_MODE_LSB 0
`define MCG_C1_INT_REF_SELECT_BIT 3
`define MCG_C1_INT_REF_OUTPUT_ENABLE_BIT 4
`define MCG_C1_INT_REF_STOP_ENABLE_BIT 5
`define MCG_C1_REFERENCE_DIVIDER_LSB 8
`define MCG_C1_BUS_DIVIDER_SELECT_LSB 12
// Control two fields
`define MCG_C2_EXT_REF_OUTPUT_ENABLE_BIT 0
`define MCG_C2_EXT_REF_STOP_ENABLE_BIT 1
`define MCG_C2_LP_BIT 2
`define MCG_C2_CME_BIT 3
`define MCG_C2_RANGE_BIT 4
`define MCG_C2_EXTEN_BIT 5
// Trim fields
`define MCG_TRIM_FINE_BIT 8
// Reset values
`define MCG_BUS_DIVIDER_SELECT_RST 2'h1
`define MCG_TRIM_RST 8'h80
`define MCG_REFERENCE_DIVIDER_RST 3'h0
// Timing: reference settle and lock times
`define MCG_IREF_SETTLE_NS 6000
`define MCG_FLL_LOCK_NS 1000000
`define MCG_CLK_NS 25
// Loss-of-clock windows in pclk cycles without an external edge
`define MCG_LOC_HIGH_CYC 16'd400
`define MCG_LOC_LOW_CYC 16'd8000
`endif

//--- rtl/mcg_pkg.sv
// Types shared by the clock generator
package mcg_pkg;
  typedef enum logic [2:0] {
    MCG_FEI, MCG_FEE, MCG_FBI, MCG_FBE, MCG_PEE, MCG_PBE, MCG_BYPASSED_LOWPOWER_INTERNAL_MODE, MCG_BYPASSED_LOWPOWER_EXTERNAL_MODE
  } mcg_mode_e;
  typedef logic [2:0] mcg_div_t;
endpackage : mcg_pkg

//--- rtl/mcg_top.sv
// Clock generator control: dividers, trim, reference outputs, monitor and APB registers
//
// Overview of operation
// - Bus divider changes take effect at the next main clock period boundary, no mode change needed.
// - Low power bit in bypass modes stops FLL/PLL; zero keeps them running.
// - Internal reference output enable drives internal reference clock output.
// - Larger coarse trim lengthens internal reference period, lowering frequency.
// - Trim alters main clock only in FLL_ENGAGED_INTERNAL_MODE, FLL_BYPASSED_INTERNAL_MODE and BYPASSED_LOWPOWER_INTERNAL_MODE modes.
// - Trim fields initialised only by power-on reset, kept through others.
// - Internal stop enable plus output enable keeps internal reference in stop.
// - External output enable presents external reference clock output.
// - Internal select one keeps external reference away from FLL/PLL.
// - External reference kept in stop by enables or external modes.
// - Monitor enabled resets chip when external reference too slow.
// - Monitor reset sets the loss-of-clock flag in reset status.
// - Fixed clock is divided reference; valid only at most quarter main.
// - In bypass, fixed clock invalid for low bus and reference dividers.
// - Valid indicator is one while fixed clock valid, else zero.
// - Reset leaves FLL_ENGAGED_INTERNAL_MODE mode with bus divider at divide-by-2.
// - FLL acquires lock only after internal reference settles, then locks.
// - From reset mode only FEE, FBE, FLL_BYPASSED_INTERNAL_MODE may be entered directly.
`timescale 1ns/1ps
`include "mcg_params.svh"

module mcg_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources and state
  input wire logic ext_ref_in,
  input wire logic stop_mode,
  // Clock outputs and enables
  output logic main_clock_out,
  output logic int_ref_clock_out,
  output logic ext_ref_clock_out,
  output logic fixed_freq_clock,
  output logic fixed_freq_valid,
  output logic fll_enable,
  output logic pll_enable,
  output logic int_ref_run,
  output logic ext_ref_run,
  output logic loc_reset_req,
  output mcg_pkg::mcg_mode_e cur_mode
);
  import mcg_pkg::*;

  localparam int IREF_SETTLE_CYC = (`MCG_IREF_SETTLE_NS + `MCG_CLK_NS - 1) / `MCG_CLK_NS;
  localparam int FLL_LOCK_CYC = `MCG_FLL_LOCK_NS / `MCG_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  mcg_mode_e mode_r;
  logic int_ref_select_r, int_ref_output_enable_r, int_ref_stop_enable_r;
  mcg_div_t reference_divider_r;
  logic [1:0] bus_divider_select_r;
  logic ext_ref_output_enable_r, ext_ref_stop_enable_r, lp_r, cme_r, range_r, exten_r;
  logic [7:0] trim_r;
  logic fine_trim_r;
  logic loc_flag_r;
  logic fll_locked_r;

  wire wr_en = psel && penable && pwrite;

  function automatic logic is_bypass(input mcg_mode_e m);
    return m inside {MCG_FBI, MCG_FBE, MCG_PBE, MCG_BYPASSED_LOWPOWER_INTERNAL_MODE, MCG_BYPASSED_LOWPOWER_EXTERNAL_MODE};
  endfunction : is_bypass

  function automatic logic is_ext(input mcg_mode_e m);
    return m inside {MCG_FEE, MCG_FBE, MCG_PEE, MCG_PBE, MCG_BYPASSED_LOWPOWER_EXTERNAL_MODE};
  endfunction : is_ext

  // Allowed mode moves; reset mode may only go to FEE, FBE, FLL_BYPASSED_INTERNAL_MODE
  function automatic logic move_ok(input mcg_mode_e from, input mcg_mode_e to);
    logic ok;
    ok = 1'b1;
    if (from == MCG_FEI)
      ok = to inside {MCG_FEI, MCG_FEE, MCG_FBE, MCG_FBI};
    return ok;
  endfunction : move_ok

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MCG_FEI;
      int_ref_select_r <= 1'b1;
      int_ref_output_enable_r <= 1'b0;
      int_ref_stop_enable_r <= 1'b0;
      reference_divider_r <= `MCG_REFERENCE_DIVIDER_RST;
      bus_divider_select_r <= `MCG_BUS_DIVIDER_SELECT_RST;
    end else if (wr_en && paddr == `MCG_OFF_CTRL1) begin
      if (move_ok(mode_r, mcg_mode_e'(pwdata[`MCG_C1_MODE_LSB +: 3])))
        mode_r <= mcg_mode_e'(pwdata[`MCG_C1_MODE_LSB +: 3]);
      int_ref_select_r <= pwdata[`MCG_C1_INT_REF_SELECT_BIT];
      int_ref_output_enable_r <= pwdata[`MCG_C1_INT_REF_OUTPUT_ENABLE_BIT];
      int_ref_stop_enable_r <= pwdata[`MCG_C1_INT_REF_STOP_ENABLE_BIT];
      reference_divider_r <= pwdata[`MCG_C1_REFERENCE_DIVIDER_LSB +: 3];
      bus_divider_select_r <= pwdata[`MCG_C1_BUS_DIVIDER_SELECT_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ref_output_enable_r <= 1'b0;
      ext_ref_stop_enable_r <= 1'b0;
      lp_r <= 1'b0;
      cme_r <= 1'b0;
      range_r <= 1'b0;
      exten_r <= 1'b0;
    end else if (wr_en && paddr == `MCG_OFF_CTRL2) begin
      ext_ref_output_enable_r <= pwdata[`MCG_C2_EXT_REF_OUTPUT_ENABLE_BIT];
      ext_ref_stop_enable_r <= pwdata[`MCG_C2_EXT_REF_STOP_ENABLE_BIT];
      lp_r <= pwdata[`MCG_C2_LP_BIT];
      cme_r <= pwdata[`MCG_C2_CME_BIT];
      range_r <= pwdata[`MCG_C2_RANGE_BIT];
      exten_r <= pwdata[`MCG_C2_EXTEN_BIT];
    end
  end

  // Trim lives on power-on reset only so it survives ordinary resets
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      trim_r <= `MCG_TRIM_RST;
      fine_trim_r <= 1'b0;
    end else if (wr_en && paddr == `MCG_OFF_TRIM) begin
      trim_r <= pwdata[7:0];
      fine_trim_r <= pwdata[`MCG_TRIM_FINE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path, zero wait states
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `MCG_OFF_CTRL1: rd_mux = {16'h0000, 2'b00, bus_divider_select_r, 1'b0, reference_divider_r, 2'b00,
                                int_ref_stop_enable_r, int_ref_output_enable_r, int_ref_select_r, mode_r};
      `MCG_OFF_CTRL2: rd_mux = {26'h000_0000, exten_r, range_r, cme_r, lp_r,
                                ext_ref_stop_enable_r, ext_ref_output_enable_r};
      `MCG_OFF_TRIM: rd_mux = {23'h00_0000, fine_trim_r, trim_r};
      `MCG_OFF_STAT: rd_mux = {28'h000_0000, fll_locked_r, fixed_freq_valid,
                               int_ref_run, ext_ref_run};
      `MCG_OFF_RSTAT: rd_mux = {31'h0000_0000, loc_flag_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  wire addr_ok = paddr inside {`MCG_OFF_CTRL1, `MCG_OFF_CTRL2, `MCG_OFF_TRIM,
                               `MCG_OFF_STAT, `MCG_OFF_RSTAT};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal reference oscillator model: half period grows with trim
  logic [9:0] iref_cnt_r;
  logic iref_clk_r;
  wire iref_osc_on = !stop_mode || (int_ref_stop_enable_r && int_ref_output_enable_r);
  wire [9:0] iref_half = {1'b0, trim_r, fine_trim_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iref_cnt_r <= 10'h000;
      iref_clk_r <= 1'b0;
    end else if (iref_osc_on) begin
      if (iref_cnt_r >= iref_half) begin
        iref_cnt_r <= 10'h000;
        iref_clk_r <= !iref_clk_r;
      end else begin
        iref_cnt_r <= iref_cnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      int_ref_run <= 1'b0;
    else
      int_ref_run <= iref_osc_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      int_ref_clock_out <= 1'b0;
    else
      int_ref_clock_out <= int_ref_output_enable_r && iref_clk_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // External reference: synchroniser, output, stop keep-alive
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_ref_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  wire ext_edge = ext_s2_r && !ext_s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ref_clock_out <= 1'b0;
      ext_ref_run <= 1'b0;
    end else begin
      ext_ref_clock_out <= ext_ref_output_enable_r && ext_s2_r;
      ext_ref_run <= exten_r && (!stop_mode || (ext_ref_stop_enable_r && ext_ref_output_enable_r)
                                 || is_ext(mode_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FLL / PLL enables and lock timing
  // Loop reference: external only when internal select is clear
  wire loop_ref_edge = int_ref_select_r ? (iref_cnt_r == 10'h000) : ext_edge;
  wire lp_off = lp_r && is_bypass(mode_r);
  wire pll_mode = mode_r inside {MCG_PEE, MCG_PBE};

  logic [31:0] lock_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fll_enable <= 1'b0;
      pll_enable <= 1'b0;
    end else begin
      fll_enable <= !lp_off && !pll_mode && !stop_mode;
      pll_enable <= !lp_off && pll_mode && !stop_mode;
    end
  end

  // Settle phase counts first, lock phase counts pclk cycles after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r <= 32'h0000_0000;
      fll_locked_r <= 1'b0;
    end else if (!fll_enable) begin
      lock_cnt_r <= 32'h0000_0000;
      fll_locked_r <= 1'b0;
    end else if (lock_cnt_r < 32'(IREF_SETTLE_CYC + FLL_LOCK_CYC)) begin
      // Settle span first, lock span after; both counted in pclk cycles
      lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
    end else begin
      fll_locked_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main clock: source select then glitch-free bus divider
  wire trim_src = mode_r inside {MCG_FEI, MCG_FBI, MCG_BYPASSED_LOWPOWER_INTERNAL_MODE};
  wire src_clk = trim_src ? iref_clk_r : ext_s2_r;
  logic src_d_r;
  logic [3:0] bus_divider_select_cnt_r;
  logic [1:0] bus_divider_select_act_r;
  wire src_edge = src_clk != src_d_r;

  // New divide ratio is taken only at a full period boundary, so no runt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_r <= 1'b0;
      bus_divider_select_cnt_r <= 4'h0;
      bus_divider_select_act_r <= `MCG_BUS_DIVIDER_SELECT_RST;
      main_clock_out <= 1'b0;
    end else begin
      src_d_r <= src_clk;
      if (src_edge) begin
        if (bus_divider_select_cnt_r >= 4'((1 << bus_divider_select_act_r) - 1)) begin
          bus_divider_select_cnt_r <= 4'h0;
          if (main_clock_out)
            bus_divider_select_act_r <= bus_divider_select_r;
          main_clock_out <= !main_clock_out;
        end else begin
          bus_divider_select_cnt_r <= bus_divider_select_cnt_r + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed frequency clock and its validity
  logic [7:0] ff_cnt_r;
  wire ff_bad = is_bypass(mode_r) && ((bus_divider_select_r == 2'h0 && reference_divider_r < 3'h2)
                || (bus_divider_select_r == 2'h1 && reference_divider_r < 3'h3));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_cnt_r <= 8'h00;
      fixed_freq_clock <= 1'b0;
      fixed_freq_valid <= 1'b0;
    end else begin
      fixed_freq_valid <= !ff_bad;
      if (loop_ref_edge) begin
        if (ff_cnt_r >= 8'((1 << reference_divider_r) - 1)) begin
          ff_cnt_r <= 8'h00;
          fixed_freq_clock <= !fixed_freq_clock;
        end else begin
          ff_cnt_r <= ff_cnt_r + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor: no external edge inside the range window means loss
  logic [15:0] loc_cnt_r;
  wire [15:0] loc_lim = range_r ? `MCG_LOC_HIGH_CYC : `MCG_LOC_LOW_CYC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_cnt_r <= 16'h0000;
      loc_reset_req <= 1'b0;
    end else if (!cme_r || ext_edge) begin
      loc_cnt_r <= 16'h0000;
      loc_reset_req <= 1'b0;
    end else if (loc_cnt_r >= loc_lim) begin
      loc_reset_req <= 1'b1;
    end else begin
      loc_cnt_r <= loc_cnt_r + 16'h0001;
    end
  end

  // Cause flag survives the reset it triggers; cleared by power-on or by writing one to bit 0
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n)
      loc_flag_r <= 1'b0;
    else if (loc_reset_req)
      loc_flag_r <= 1'b1;
    else if (wr_en && paddr == `MCG_OFF_RSTAT && pwdata[0])
      loc_flag_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cur_mode <= MCG_FEI;
    else
      cur_mode <= mode_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_reset_mode: assert property (@(posedge pclk) $rose(presetn) |-> mode_r == MCG_FEI
                                   && bus_divider_select_r == 2'h1) else $error("bad reset mode");
  chk_mode_entry: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mode_r) == MCG_FEI && mode_r != MCG_FEI |-> mode_r inside {MCG_FEE, MCG_FBE,
    MCG_FBI}) else $error("illegal first move");
  chk_bus_divider_select_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `MCG_OFF_CTRL1 |=> bus_divider_select_r == $past(pwdata[13:12]))
    else $error("bus divider not applied");
  chk_ff_valid: assert property (@(posedge pclk) disable iff (!presetn)
    ff_bad |=> !fixed_freq_valid) else $error("valid while invalid");
  chk_ff_valid_set: assert property (@(posedge pclk) disable iff (!presetn)
    !ff_bad ##1 !ff_bad |-> fixed_freq_valid) else $error("valid low");
  chk_irclk_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !int_ref_output_enable_r ##1 !int_ref_output_enable_r |-> !int_ref_clock_out) else $error("iref out leak");
  chk_erclk_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_ref_output_enable_r ##1 !ext_ref_output_enable_r |-> !ext_ref_clock_out) else $error("eref out leak");
  chk_lp_off: assert property (@(posedge pclk) disable iff (!presetn)
    lp_off |=> !fll_enable && !pll_enable) else $error("loop not gated");
  chk_loc_flag: assert property (@(posedge pclk) disable iff (!por_n)
    loc_reset_req |=> loc_flag_r) else $error("loss flag missing");
  chk_loc_off: assert property (@(posedge pclk) disable iff (!presetn)
    !cme_r |=> !loc_reset_req) else $error("monitor fired while off");
  chk_iref_stop: assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode && int_ref_stop_enable_r && int_ref_output_enable_r |=> int_ref_run) else $error("iref stopped");
  chk_eref_stop: assert property (@(posedge pclk) disable iff (!presetn)
    exten_r && stop_mode && is_ext(mode_r) |=> ext_ref_run) else $error("eref stopped");
  chk_loc_fire: assert property (@(posedge pclk) disable iff (!presetn)
    cme_r && !ext_edge && loc_cnt_r >= loc_lim |=> loc_reset_req) else $error("loss missed");
endmodule : mcg_top

//--- test/mpc_ext_ref_model.sv
// External reference source model driving the reference pin of the clock generator
`timescale 1ns/1ps
module mpc_ext_ref_model #(
  parameter int HALF_NS = 100
) (
  // Control
  input wire logic run,
  // Pin
  output logic ext_ref_in
);
  // A failed source freezes the pin at its last level, like a stalled crystal
  initial begin
    ext_ref_in = 1'b0;
    #7;
    forever begin
      #HALF_NS;
      if (run) begin
        ext_ref_in = ~ext_ref_in;
      end
    end
  end
endmodule : mpc_ext_ref_model

//--- test/multi_purpose_clock_generator_bench.sv
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
`include "mcg_params.svh"
module multi_purpose_clock_generator_bench;
  import mcg_pkg::*;
  logic pclk, presetn, por_n, psel, penable, pwrite, stop_mode, ext_run, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ext_ref_in, main_clock_out, int_ref_clock_out, ext_ref_clock_out;
  logic fixed_freq_clock, fixed_freq_valid, fll_enable, pll_enable, int_ref_run, ext_ref_run;
  logic loc_reset_req;
  mcg_mode_e cur_mode;
  int miscompares = 0;
  int checks_done = 0;
  int g0, g1;
  mcg_top uut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_ref_in, .stop_mode, .main_clock_out, .int_ref_clock_out,
    .ext_ref_clock_out, .fixed_freq_clock, .fixed_freq_valid, .fll_enable, .pll_enable,
    .int_ref_run, .ext_ref_run, .loc_reset_req, .cur_mode);
  mpc_ext_ref_model #(.HALF_NS(100)) ext_src (.run(ext_run), .ext_ref_in(ext_ref_in));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_word
  task automatic check_bit(input string what, input logic exp, input logic seen);
    check_word(what, {31'h0, exp}, {31'h0, seen});
  endtask : check_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic warm();
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(5);
    presetn <= 1'b1;
  endtask : warm
  function automatic logic [31:0] c1(input logic [2:0] m, input logic irf, input logic ien,
      input logic isten, input logic [2:0] rv, input logic [1:0] bd);
    return (32'(m) << `MCG_C1_MODE_LSB) | (32'(irf) << `MCG_C1_INT_REF_SELECT_BIT) |
      (32'(ien) << `MCG_C1_INT_REF_OUTPUT_ENABLE_BIT) | (32'(isten) << `MCG_C1_INT_REF_STOP_ENABLE_BIT) |
      (32'(rv) << `MCG_C1_REFERENCE_DIVIDER_LSB) | (32'(bd) << `MCG_C1_BUS_DIVIDER_SELECT_LSB);
  endfunction : c1
  function automatic logic [31:0] c2(input logic ex, input logic rg, input logic cm,
      input logic lpg, input logic est, input logic een);
    return (32'(ex) << `MCG_C2_EXTEN_BIT) | (32'(rg) << `MCG_C2_RANGE_BIT) |
      (32'(cm) << `MCG_C2_CME_BIT) | (32'(lpg) << `MCG_C2_LP_BIT) |
      (32'(est) << `MCG_C2_EXT_REF_STOP_ENABLE_BIT) | (32'(een) << `MCG_C2_EXT_REF_OUTPUT_ENABLE_BIT);
  endfunction : c2
  function automatic logic pick(input int sel);
    return (sel == 0) ? main_clock_out : (sel == 1) ? int_ref_clock_out :
      (sel == 2) ? ext_ref_clock_out : fixed_freq_clock;
  endfunction : pick
  // Skips the first partial interval so the result is one whole half period
  task automatic edge_gap(input int sel, output int gap);
    logic s;
    int n;
    for (int k = 0; k < 3; k++) begin
      s = pick(sel);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pick(sel) === s && n < 3000);
    end
    gap = n;
  endtask : edge_gap
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_modes();
    mcg_mode_e bad [4] = '{MCG_PEE, MCG_PBE, MCG_BYPASSED_LOWPOWER_INTERNAL_MODE, MCG_BYPASSED_LOWPOWER_EXTERNAL_MODE};
    apb(1'b0, `MCG_OFF_CTRL1, 32'h0);
    check_word("ctrl1 reset", 32'h0000_1008, rd);
    check_word("mode reset", {29'h0, MCG_FEI}, {29'h0, cur_mode});
    apb(1'b0, `MCG_OFF_TRIM, 32'h0);
    check_word("trim reset", 32'h0000_0080, rd);
    apb(1'b0, 12'h020, 32'h0);
    check_bit("unmapped error", 1'b1, err);
    check_word("unmapped read", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      wr(`MCG_OFF_CTRL1, c1(bad[i], 1'b0, 1'b0, 1'b0, 3'h0, 2'h1));
      cyc(3);
      check_word("illegal first move", {29'h0, MCG_FEI}, {29'h0, cur_mode});
    end
    wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b1, 1'b0, 1'b0, 3'h0, 2'h1));
    cyc(3);
    check_word("legal first move", {29'h0, MCG_FBI}, {29'h0, cur_mode});
    wr(`MCG_OFF_CTRL2, c2(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    cyc(3);
    check_bit("fll gated", 1'b0, fll_enable);
    check_bit("pll gated", 1'b0, pll_enable);
    wr(`MCG_OFF_CTRL2, c2(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    cyc(3);
    check_bit("fll kept running", 1'b1, fll_enable);
  endtask : t_reset_modes
  task automatic t_intref();
    wr(`MCG_OFF_TRIM, 32'h0000_0002);
    wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b1, 1'b1, 1'b0, 3'h0, 2'h1));
    edge_gap(1, g0);
    wr(`MCG_OFF_TRIM, 32'h0000_0004);
    edge_gap(1, g1);
    check_bit("larger trim slower", 1'b1, g1 > g0);
    edge_gap(0, g1);
    wr(`MCG_OFF_TRIM, 32'h0000_0002);
    edge_gap(0, g0);
    check_bit("main follows trim", 1'b1, g0 < g1);
    wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b0, 1'b0, 1'b0, 3'h0, 2'h0));
    edge_gap(0, g1);
    check_word("divider applied", 32'(g0), 32'(2 * g1));
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      check_bit("int ref out idle", 1'b0, int_ref_clock_out);
    end
    wr(`MCG_OFF_TRIM, 32'h0000_0103);
    warm();
    apb(1'b0, `MCG_OFF_TRIM, 32'h0);
    check_word("trim kept over reset", 32'h0000_0103, rd);
  endtask : t_intref
  task automatic t_fixed();
    logic ex;
    wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b1, 1'b0, 1'b0, 3'h0, 2'h1));
    for (int bd = 0; bd < 2; bd++) begin
      for (int rv = 0; rv < 4; rv++) begin
        ex = !((bd == 0 && rv < 2) || (bd == 1 && rv < 3));
        wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b1, 1'b0, 1'b0, 3'(rv), 2'(bd)));
        cyc(40);
        check_bit("fixed valid", ex, fixed_freq_valid);
        apb(1'b0, `MCG_OFF_STAT, 32'h0);
        check_bit("fixed valid status", ex, rd[2]);
      end
    end
    wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b1, 1'b0, 1'b0, 3'h6, 2'h1));
    wr(`MCG_OFF_TRIM, 32'h0000_0002);
    wr(`MCG_OFF_CTRL1, c1(MCG_FBI, 1'b1, 1'b0, 1'b0, 3'h3, 2'h1));
    cyc(4);
    check_bit("fixed valid restored", 1'b1, fixed_freq_valid);
    edge_gap(3, g0);
    check_word("fixed clock half period", 32'd40, 32'(g0));
    warm();
  endtask : t_fixed
  task automatic t_extref();
    wr(`MCG_OFF_CTRL2, c2(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
    edge_gap(2, g0);
    check_word("ext ref out half period", 32'h0000_0004, 32'(g0));
    wr(`MCG_OFF_CTRL2, c2(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
    cyc(4);
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      check_bit("ext ref out idle", 1'b0, ext_ref_clock_out);
    end
    stop_mode <= 1'b1;
    cyc(4);
    check_bit("ext stop one enable", 1'b0, ext_ref_run);
    wr(`MCG_OFF_CTRL2, c2(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
    cyc(4);
    check_bit("ext stop both enables", 1'b1, ext_ref_run);
    wr(`MCG_OFF_CTRL1, c1(MCG_FEI, 1'b1, 1'b1, 1'b1, 3'h0, 2'h1));
    cyc(4);
    check_bit("int stop both enables", 1'b1, int_ref_run);
    wr(`MCG_OFF_CTRL1, c1(MCG_FEI, 1'b1, 1'b0, 1'b1, 3'h0, 2'h1));
    cyc(4);
    check_bit("int stop one enable", 1'b0, int_ref_run);
    wr(`MCG_OFF_CTRL2, c2(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(`MCG_OFF_CTRL1, c1(MCG_FBE, 1'b0, 1'b0, 1'b0, 3'h0, 2'h1));
    cyc(4);
    check_word("enter external bypass", {29'h0, MCG_FBE}, {29'h0, cur_mode});
    check_bit("ext stop external mode", 1'b1, ext_ref_run);
    stop_mode <= 1'b0;
    edge_gap(0, g0);
    wr(`MCG_OFF_TRIM, 32'h0000_0010);
    edge_gap(0, g1);
    check_word("main ignores trim", 32'(g0), 32'(g1));
  endtask : t_extref
  task automatic t_loss();
    int n;
    wr(`MCG_OFF_CTRL2, c2(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
    n = 0;
    repeat (500) begin
      @(posedge pclk);
      n += (loc_reset_req !== 1'b0);
    end
    check_word("no loss while running", 32'h0, 32'(n));
    ext_run <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (loc_reset_req !== 1'b1 && n < 1000);
    check_bit("loss detect time", 1'b1, n >= 390 && n <= 412);
    warm();
    ext_run <= 1'b1;
    apb(1'b0, `MCG_OFF_RSTAT, 32'h0);
    check_word("loss flag set", 32'h0000_0001, rd);
    wr(`MCG_OFF_RSTAT, 32'h0000_0001);
    apb(1'b0, `MCG_OFF_RSTAT, 32'h0);
    check_word("loss flag cleared", 32'h0, rd);
  endtask : t_loss
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stop_mode = 1'b0;
    ext_run = 1'b1;
    cyc(5);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_reset_modes();
    t_intref();
    t_fixed();
    t_extref();
    t_loss();
    results();
  end
  // Whole run needs a few thousand cycles; a hang is cut well before the overall budget
  initial begin
    cyc(40000);
    miscompares++;
    results();
  end
endmodule : multi_purpose_clock_generator_bench
